// file: design/pmcg_gate_bank.sv
/*
  One 16-bit gate control register with its per-unit clock enable,
  register access and functional run outputs, all from flip-flops.
  Assumes writes arrive as a one-cycle strobe in the system clock domain.
*/
`timescale 1ns/1ps
module pmcg_gate_bank
  import pmcg_pkg::*;
#(
  parameter logic [15:0] IMPL_MASK   = 16'hffff,
  parameter logic [15:0] NOFUNC_MASK = 16'h0000
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Register write
  input  wire logic        wr_en,
  input  wire pmcg_wr_t    wr,
  // Unit side inputs
  input  wire logic [15:0] module_function_enable,
  input  wire logic [15:0] module_stop_in_idle,
  input  wire logic        cpu_idle,
  // Outputs
  output logic [15:0]      gate_reg,
  output logic [15:0]      clk_en_reg,
  output logic [15:0]      access_reg,
  output logic [15:0]      run_reg
);

  // ***************************************************************
  // Next values
  // ***************************************************************
  logic [15:0] gate_next;
  logic [15:0] idle_stop;
  logic [15:0] func_ok;
  logic [15:0] run_next;

  // Only implemented bits in enabled lanes take the written value
  assign gate_next = wr_en ?
    ((gate_reg & ~wr.lanes) | (wr.data & wr.lanes)) & IMPL_MASK
    : gate_reg;
  // Stop-in-idle only bites while the core sits in Idle
  assign idle_stop = {16{cpu_idle}} & module_stop_in_idle;
  // Units without an enable bit are run by gating and idle stop alone
  assign func_ok   = module_function_enable | NOFUNC_MASK;
  assign run_next  = ~gate_next & func_ok & ~idle_stop & IMPL_MASK;

  // ***************************************************************
  // Registers
  // ***************************************************************
  // Enables follow the next value so gating acts on the next cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gate_reg   <= PMCG_GATE_RESET;
      clk_en_reg <= IMPL_MASK;
      access_reg <= IMPL_MASK;
      run_reg    <= 16'h0000;
    end else begin
      gate_reg   <= gate_next;
      clk_en_reg <= ~gate_next & IMPL_MASK;
      access_reg <= ~gate_next & IMPL_MASK;
      run_reg    <= run_next;
    end
  end

endmodule

// file: design/pmcg_pkg.sv
/*
  Package for the peripheral clock gating block: register offsets, field
  layouts, reset values and the carrier types shared by the design files.
  Assumes a 32-bit classic Wishbone bus with byte addressing.
*/
package pmcg_pkg;

  // ***************************************************************
  // Sizes
  // ***************************************************************
  localparam int unsigned PMCG_NUM_REGS = 4;
  localparam int unsigned PMCG_REG_W    = 16;
  localparam int unsigned PMCG_ADR_W    = 8;

  // ***************************************************************
  // Register byte offsets
  // ***************************************************************
  localparam logic [7:0] PERIPH_GATE_CTRL_1_OFS = 8'h00;
  localparam logic [7:0] PERIPH_GATE_CTRL_2_OFS = 8'h04;
  localparam logic [7:0] PERIPH_GATE_CTRL_3_OFS = 8'h08;
  localparam logic [7:0] PERIPH_GATE_CTRL_4_OFS = 8'h0c;
  localparam logic [7:0] PMCG_STATUS_OFS        = 8'h10;

  // ***************************************************************
  // Reset values and implemented-bit masks
  // ***************************************************************
  localparam logic [15:0] PMCG_GATE_RESET = 16'h0000;
  // Timers 15..11, I2C1 7, UART2 6, UART1 5, SPI2 4, SPI1 3, ADC 0
  localparam logic [15:0] PMCG_IMPL_1 = 16'hf8f9;
  // Input capture 13..8, output compare 5..0
  localparam logic [15:0] PMCG_IMPL_2 = 16'h3f3f;
  // Comparator 10, PMP 8, CRC 7, DAC 6, UART3 3, I2C3 2, I2C2 1
  localparam logic [15:0] PMCG_IMPL_3 = 16'h05ce;
  // UART4 5, ref clock out 3, charge timer 2, voltage detect 1, USB 0
  localparam logic [15:0] PMCG_IMPL_4 = 16'h002f;

  // Units that have no functional enable of their own
  localparam logic [15:0] PMCG_NOFUNC_1 = 16'h0000;
  localparam logic [15:0] PMCG_NOFUNC_2 = 16'h3f3f;
  localparam logic [15:0] PMCG_NOFUNC_3 = 16'h0000;
  localparam logic [15:0] PMCG_NOFUNC_4 = 16'h0000;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int unsigned TIMER5_GATE_OFF_BIT        = 15;
  localparam int unsigned TIMER1_GATE_OFF_BIT        = 11;
  localparam int unsigned I2C_FIRST_GATE_OFF_BIT     = 7;
  localparam int unsigned ADC_GATE_OFF_BIT           = 0;
  localparam int unsigned INCAP6_GATE_OFF_BIT        = 13;
  localparam int unsigned INCAP1_GATE_OFF_BIT        = 8;
  localparam int unsigned OUTCMP6_GATE_OFF_BIT       = 5;
  localparam int unsigned OUTCMP1_GATE_OFF_BIT       = 0;
  localparam int unsigned COMPARATOR_GATE_OFF_BIT    = 10;
  localparam int unsigned USB_CTRL_GATE_OFF_BIT      = 0;
  localparam int unsigned PMCG_STAT_IDLE_BIT         = 0;

  // ***************************************************************
  // Carrier types
  // ***************************************************************
  typedef logic [PMCG_NUM_REGS-1:0][PMCG_REG_W-1:0] pmcg_vec_t;

  typedef struct packed {
    logic [PMCG_ADR_W-1:0] adr;
    logic [31:0]           dat;
    logic [3:0]            sel;
    logic                  we;
  } pmcg_wb_req_t;

  typedef struct packed {
    logic [PMCG_REG_W-1:0] data;
    logic [PMCG_REG_W-1:0] lanes;
  } pmcg_wr_t;

endpackage

// file: design/pmcg_top.sv
/*
  Peripheral clock gating controller: four gate control registers over a
  classic Wishbone slave, per-unit clock enables, register access enables
  and functional run enables.
  Assumes one 10 MHz system clock, asynchronous active-low reset, and that
  unit-side enable and idle signals come from logic on the same clock.
*/
`timescale 1ns/1ps
module pmcg_top
  import pmcg_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Unit side status
  input  wire pmcg_vec_t   module_function_enable,
  input  wire pmcg_vec_t   module_stop_in_idle,
  input  wire logic        cpu_idle,
  // Per-unit enables
  output pmcg_vec_t        module_clk_en,
  output pmcg_vec_t        module_reg_access,
  output pmcg_vec_t        module_run
);

  // ***************************************************************
  // Bus decode
  // ***************************************************************
  pmcg_wb_req_t req;
  logic         ack_reg;
  logic [31:0]  dat_reg;
  logic         bus_act;
  logic         wr_go;
  logic [3:0]   hit;
  logic         hit_stat;
  pmcg_wr_t     wr;
  pmcg_vec_t    gate_q;
  logic [31:0]  rd_next;

  // Gather the request fields
  assign req      = '{adr: wb_adr_i, dat: wb_dat_i,
                      sel: wb_sel_i, we: wb_we_i};
  assign bus_act  = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where the master sees ack
  assign wr_go    = bus_act & req.we & ack_reg;
  assign hit[0]   = req.adr == PERIPH_GATE_CTRL_1_OFS;
  assign hit[1]   = req.adr == PERIPH_GATE_CTRL_2_OFS;
  assign hit[2]   = req.adr == PERIPH_GATE_CTRL_3_OFS;
  assign hit[3]   = req.adr == PERIPH_GATE_CTRL_4_OFS;
  assign hit_stat = req.adr == PMCG_STATUS_OFS;
  // Byte lanes 0 and 1 cover the 16-bit register; upper lanes unused
  assign wr.data  = req.dat[15:0];
  assign wr.lanes = {{8{req.sel[1]}}, {8{req.sel[0]}}};

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    rd_next = 32'h0000_0000;
    for (int i = 0; i < PMCG_NUM_REGS; i++) begin
      if (hit[i]) begin
        rd_next = {16'h0000, gate_q[i]};
      end
    end
    if (hit_stat) begin
      rd_next[PMCG_STAT_IDLE_BIT] = cpu_idle;
    end
  end

  // ***************************************************************
  // Bus answer
  // ***************************************************************
  // One wait state; ack falls in the cycle after it was given
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_act & ~ack_reg;
      if (bus_act & ~ack_reg) begin
        dat_reg <= rd_next;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // ***************************************************************
  // Gate registers, one bank per control register
  // ***************************************************************
  // First register: timers, serial units and ADC
  pmcg_gate_bank #(
    .IMPL_MASK   (PMCG_IMPL_1),
    .NOFUNC_MASK (PMCG_NOFUNC_1)
  ) u_bank1 (
    .clk                    (clk),
    .rstn                   (rstn),
    .wr_en                  (wr_go & hit[0]),
    .wr                     (wr),
    .module_function_enable (module_function_enable[0]),
    .module_stop_in_idle    (module_stop_in_idle[0]),
    .cpu_idle               (cpu_idle),
    .gate_reg               (gate_q[0]),
    .clk_en_reg             (module_clk_en[0]),
    .access_reg             (module_reg_access[0]),
    .run_reg                (module_run[0])
  );

  // Second register: capture and compare, no function enables
  pmcg_gate_bank #(
    .IMPL_MASK   (PMCG_IMPL_2),
    .NOFUNC_MASK (PMCG_NOFUNC_2)
  ) u_bank2 (
    .clk                    (clk),
    .rstn                   (rstn),
    .wr_en                  (wr_go & hit[1]),
    .wr                     (wr),
    .module_function_enable (module_function_enable[1]),
    .module_stop_in_idle    (module_stop_in_idle[1]),
    .cpu_idle               (cpu_idle),
    .gate_reg               (gate_q[1]),
    .clk_en_reg             (module_clk_en[1]),
    .access_reg             (module_reg_access[1]),
    .run_reg                (module_run[1])
  );

  // Third register: analog helpers, PMP, CRC and extra serial units
  pmcg_gate_bank #(
    .IMPL_MASK   (PMCG_IMPL_3),
    .NOFUNC_MASK (PMCG_NOFUNC_3)
  ) u_bank3 (
    .clk                    (clk),
    .rstn                   (rstn),
    .wr_en                  (wr_go & hit[2]),
    .wr                     (wr),
    .module_function_enable (module_function_enable[2]),
    .module_stop_in_idle    (module_stop_in_idle[2]),
    .cpu_idle               (cpu_idle),
    .gate_reg               (gate_q[2]),
    .clk_en_reg             (module_clk_en[2]),
    .access_reg             (module_reg_access[2]),
    .run_reg                (module_run[2])
  );

  // Fourth register: UART4, clock out, charge timer, detector, USB
  pmcg_gate_bank #(
    .IMPL_MASK   (PMCG_IMPL_4),
    .NOFUNC_MASK (PMCG_NOFUNC_4)
  ) u_bank4 (
    .clk                    (clk),
    .rstn                   (rstn),
    .wr_en                  (wr_go & hit[3]),
    .wr                     (wr),
    .module_function_enable (module_function_enable[3]),
    .module_stop_in_idle    (module_stop_in_idle[3]),
    .cpu_idle               (cpu_idle),
    .gate_reg               (gate_q[3]),
    .clk_en_reg             (module_clk_en[3]),
    .access_reg             (module_reg_access[3]),
    .run_reg                (module_run[3])
  );

endmodule

// file: verif/peripheral_module_clock_gating_tb.sv
/*
  Self-checking bench for the gate controller over classic Wishbone.
  Assumes the design package, design files and checker compile first.
*/
`timescale 1ns/1ps
module peripheral_module_clock_gating_tb
  import pmcg_pkg::*;
;
  localparam pmcg_vec_t IMPL = {PMCG_IMPL_4, PMCG_IMPL_3, PMCG_IMPL_2,
                                PMCG_IMPL_1};
  localparam pmcg_vec_t NOFN = {PMCG_NOFUNC_4, PMCG_NOFUNC_3, PMCG_NOFUNC_2,
                                PMCG_NOFUNC_1};
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        idle = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat_o, v;
  logic        ack;
  pmcg_vec_t   fen = '1;
  pmcg_vec_t   stp = '0;
  pmcg_vec_t   clk_en, acc, run;
  logic [31:0] seed = 32'h1b;
  logic [15:0] gm [4];
  logic [31:0] expq [$];
  int          err_count = 0;
  int          tests_run = 0;

  always #50 clk = ~clk;

  pmcg_top u_dut (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .module_function_enable(fen),
    .module_stop_in_idle(stp), .cpu_idle(idle), .module_clk_en(clk_en),
    .module_reg_access(acc), .module_run(run));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Status reads follow the idle input; holes read zero
  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    if (a == 8'h10) return {31'h0, idle};
    if (a[7:4] == 4'h0 && a[1:0] == 2'h0) return {16'h0, gm[a[3:2]]};
    return 32'h0;
  endfunction
  task automatic check(input string nm, input logic [63:0] seen, ex);
    tests_run++;
    if (seen !== ex) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    if (!w) expq.push_back(exp_rd(a));
    {cyc, stb, we, adr, dat, sel} <= {2'h3, w, a, d, s};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    if (ack !== 1'b1) begin
      err_count++;
      end_sim();
    end
    {cyc, stb} <= 2'h0;
    if (w && a[7:4] == 4'h0 && a[1:0] == 2'h0) begin
      if (s[0]) gm[a[3:2]][7:0] = d[7:0];
      if (s[1]) gm[a[3:2]][15:8] = d[15:8];
      gm[a[3:2]] &= IMPL[a[3:2]];
    end
  endtask
  task automatic chk_ports();
    pmcg_vec_t en;
    for (int r = 0; r < 4; r++) en[r] = ~gm[r] & IMPL[r];
    @(negedge clk);
    check("clock enable", clk_en, en);
    check("register access", acc, en);
    check("run", run, en & (fen | NOFN) & ~(stp & {64{idle}}));
  endtask
  task automatic do_reset();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    check("reset enable", clk_en, IMPL);
    check("reset run", run, 64'h0);
    rstn <= 1'b1;
    for (int r = 0; r < 4; r++) gm[r] = 16'h0;
  endtask

  // Scoreboard: each read ack takes the oldest expected value
  always @(posedge clk) begin
    if (rstn && ack === 1'b1 && we === 1'b0) begin
      check("read data", dat_o, expq.pop_front());
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    do_reset();
    // Bit map written out from the rules, not taken from the package masks
    check("implemented map", clk_en,
          64'h002f_05ce_3f3f_f8f9);
    for (int r = 0; r < 5; r++) wb(1'b0, 8'(r * 4), 32'h0, 4'hf);
    $display("test reset values done");
    for (int r = 0; r < 4; r++) begin
      wb(1'b1, 8'(r * 4), 32'hffffffff, 4'hf);
      chk_ports();
      wb(1'b0, 8'(r * 4), 32'h0, 4'hf);
    end
    $display("test bit map done");
    for (int i = 0; i < 12; i++) begin
      v = rnd();
      wb(1'b1, {4'h0, v[19:18], 2'h0}, v, v[23:20]);
      chk_ports();
      wb(1'b0, {4'h0, v[19:18], 2'h0}, 32'h0, 4'hf);
    end
    // Status and holes must not disturb the gate registers
    wb(1'b1, 8'h10, 32'hffff, 4'hf);
    wb(1'b1, 8'h20, 32'hffff, 4'hf);
    wb(1'b0, 8'h20, 32'h0, 4'hf);
    chk_ports();
    $display("test random writes done");
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      v = rnd();
      fen <= {rnd(), rnd()};
      stp <= {rnd(), rnd()};
      idle <= v[3];
      @(posedge clk);
      chk_ports();
      wb(1'b0, 8'h10, 32'h0, 4'hf);
    end
    $display("test idle and enables done");
    do_reset();
    for (int r = 0; r < 4; r++) wb(1'b0, 8'(r * 4), 32'h0, 4'hf);
    chk_ports();
    $display("test second reset done");
    end_sim();
  end
endmodule

// file: verif/pmcg_properties.sv
/*
  Checker for the gate controller ports: write timing, enable relations,
  idle stop and reset values.
  Assumes it is bound to pmcg_top by name; one clock, async low reset.
*/
`timescale 1ns/1ps
module pmcg_checker
  import pmcg_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // Bus side
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_ack_o,
  // Unit side
  input wire pmcg_vec_t   module_function_enable,
  input wire pmcg_vec_t   module_stop_in_idle,
  input wire logic        cpu_idle,
  input wire pmcg_vec_t   module_clk_en,
  input wire pmcg_vec_t   module_reg_access,
  input wire pmcg_vec_t   module_run
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  localparam pmcg_vec_t IMPL = {PMCG_IMPL_4, PMCG_IMPL_3, PMCG_IMPL_2,
                                PMCG_IMPL_1};
  localparam pmcg_vec_t NOFN = {PMCG_NOFUNC_4, PMCG_NOFUNC_3, PMCG_NOFUNC_2,
                                PMCG_NOFUNC_1};
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  property p_unimpl_zero;
    ((module_clk_en | module_reg_access | module_run) & ~IMPL) == '0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("enable set on an unimplemented bit");
  property p_access_gate;
    module_reg_access == module_clk_en;
  endproperty
  a_access_gate: assert property (p_access_gate)
    else $error("register access differs from clock enable");
  property p_run_clk;
    (module_run & ~module_clk_en) == '0;
  endproperty
  a_run_clk: assert property (p_run_clk)
    else $error("unit runs without its clock");
  // Run is one edge behind the unit-side inputs
  property p_run_eq;
    $past(rstn) |-> module_run == (module_clk_en &
      ($past(module_function_enable) | NOFN) &
      ~($past(module_stop_in_idle) & {64{$past(cpu_idle)}}));
  endproperty
  a_run_eq: assert property (p_run_eq)
    else $error("run enable wrong");
  property p_idle_stop;
    $past(cpu_idle) |-> (module_run & $past(module_stop_in_idle)) == '0;
  endproperty
  a_idle_stop: assert property (p_idle_stop)
    else $error("unit runs in idle with stop set");
  property p_write_lands;
    wb_ack_o && wb_we_i && wb_sel_i[1:0] == 2'h3 && wb_adr_i[7:4] == 4'h0
      && wb_adr_i[1:0] == 2'h0 |=> module_clk_en[$past(wb_adr_i[3:2])]
      == (~$past(wb_dat_i[15:0]) & IMPL[$past(wb_adr_i[3:2])]);
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("gate write not applied on next cycle");
  property p_reset_val;
    $rose(rstn) |-> module_clk_en == IMPL && module_run == '0;
  endproperty
  a_reset_val: assert property (p_reset_val)
    else $error("enables wrong after reset");
  // Clock enables move only on a write edge, so no stray clock pulse
  property p_no_glitch;
    $changed(module_clk_en) |-> $past(wb_ack_o) && $past(wb_we_i);
  endproperty
  a_no_glitch: assert property (p_no_glitch)
    else $error("clock enable changed without a write");
  c_write: cover property (wb_ack_o && wb_we_i);
  c_idle: cover property (cpu_idle && module_stop_in_idle != '0);
  c_gated: cover property (module_clk_en != IMPL);
endmodule

bind pmcg_top pmcg_checker u_chk (.clk(clk), .rstn(rstn),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o),
  .module_function_enable(module_function_enable),
  .module_stop_in_idle(module_stop_in_idle), .cpu_idle(cpu_idle),
  .module_clk_en(module_clk_en), .module_reg_access(module_reg_access),
  .module_run(module_run));
